/* fcm_cmd_interp.v */
// floppy command interpreter: dump, read id, perpendicular, lock, invalid, implied seek
// Operation
// - read id latches first good identifier
// - read id returns three status, C H R N
// - invalid opcode: no-op, one byte 80h
// - dump gives sector count after format
// - dump gives end of track after transfer
// - perpendicular bits never drive select pins
// - transfer family shares results; format takes five parameters, the rest eight
// - transfers decoded by low five bits
// - implied seek before read, write and verify when enabled
// - implied seek silent, no extra bytes
// - drive busy during implied seek
// - seek failure gives error and cylinder
`timescale 1ns/1ps
`include "fcm_consts.vh"
module fcm_cmd_interp #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  input wire CLK_SYS, // system clock, 50 MHz
  input wire RSTN, // async reset, active low
  input wire CMD_VALID, // host writes a command/parameter byte
  input wire [7:0] CMD_DATA, // command/parameter byte
  input wire RES_POP, // host reads a result byte
  output reg [7:0] RES_DATA, // current result byte
  output reg RES_VALID, // result byte available
  output reg CMD_BUSY, // command in progress
  output reg [3:0] DRIVE_BUSY, // per-drive busy bits of main status
  input wire [7:0] SPEC_TIMES, // step rate / head unload byte
  input wire [7:0] SPEC_LOAD, // head load time / pio transfer select byte
  input wire [7:0] CFG_BYTE, // configure byte: seek enable, fifo, threshold
  input wire [7:0] PRECOMP_START_TRACK, // precompensation start track
  input wire [31:0] CYL_IN, // present cylinder numbers, drive 3..0
  output reg SEEK_REQ, // implied seek start pulse to seek engine
  output reg [1:0] SEEK_DRIVE, // drive being sought
  output reg [7:0] SEEK_CYL, // target cylinder
  input wire SEEK_DONE, // seek finished pulse
  input wire SEEK_FAIL, // seek failed, with SEEK_DONE
  input wire [7:0] SEEK_FAIL_CYL, // cylinder at failure
  output reg XFER_START, // start pulse to data transfer engine
  output reg [4:0] XFER_OP, // transfer opcode, low five bits
  input wire XFER_DONE, // transfer finished pulse
  input wire [7:0] XFER_ST0, // transfer status bytes and id
  input wire [7:0] XFER_ST1, // status byte one
  input wire [7:0] XFER_ST2, // status byte two
  input wire [31:0] XFER_CHRN, // cylinder, head, sector, size
  input wire ID_VALID, // id field read without error
  input wire [31:0] ID_CHRN, // id field cylinder/head/sector/size
  output reg [7:0] PERP_CTRL, // internal perpendicular setting
  output reg LOCK_FLAG // lock setting
);
  localparam S_IDLE = 3'h0;
  localparam S_PARAM = 3'h1;
  localparam S_SEEK = 3'h2;
  localparam S_XFER = 3'h3;
  localparam S_RID = 3'h4;
  localparam S_RESULT = 3'h5;

  reg [2:0] state;
  reg [7:0] opcode;
  reg [3:0] need;
  reg [3:0] idx;
  reg [7:0] par [0:7];
  reg last_fmt;
  reg [7:0] eot_sector;
  reg [7:0] sc_value;
  reg [3:0] res_len;
  reg [3:0] res_idx;
  reg [7:0] res_byte;
  reg push;
  reg [7:0] push_data;
  reg id_got;
  reg [7:0] ids [0:3];
  reg seek_fail;
  reg [7:0] fail_cyl;
  wire [7:0] f_dout;
  wire f_empty;
  wire f_full;
  wire is_xfer;
  wire [4:0] low5;

  assign low5 = CMD_DATA[4:0];
  // transfer family picked out by the low five bits only
  assign is_xfer = (low5 == `FCM_OP_READ) || (low5 == `FCM_OP_READ_DEL) ||
    (low5 == `FCM_OP_WRITE) || (low5 == `FCM_OP_WRITE_DEL) ||
    (low5 == `FCM_OP_VERIFY) || (low5 == `FCM_OP_FORMAT);

  fcm_result_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .flush(CMD_VALID && state == S_IDLE),
    .push(push),
    .din(push_data),
    .pop(RES_POP && RES_VALID),
    .dout(f_dout),
    .empty(f_empty),
    .full(f_full)
  );

  ////////////////////////////////////////////////////////////////////////////
  // result byte selection
  always @* begin
    res_byte = 8'h00;
    if (opcode == `FCM_OP_DUMP) begin
      case (res_idx)
        4'h0: res_byte = CYL_IN[7:0];
        4'h1: res_byte = CYL_IN[15:8];
        4'h2: res_byte = CYL_IN[23:16];
        4'h3: res_byte = CYL_IN[31:24];
        4'h4: res_byte = SPEC_TIMES;
        4'h5: res_byte = SPEC_LOAD;
        4'h6: res_byte = last_fmt ? sc_value : eot_sector;
        4'h7: res_byte = {LOCK_FLAG, 1'b0, PERP_CTRL[5:0]};
        4'h8: res_byte = {1'b0, CFG_BYTE[6:0]};
        4'h9: res_byte = PRECOMP_START_TRACK;
        default: res_byte = 8'h00;
      endcase
    end else if (opcode[6:0] == `FCM_OP_LOCK) begin
      res_byte = 8'h00;
      res_byte[`FCM_LOCK_BIT] = LOCK_FLAG;
    end else if (res_len == 4'h1) begin
      res_byte = `FCM_ST0_INVALID;
    end else begin
      case (res_idx)
        4'h0: res_byte = XFER_ST0;
        4'h1: res_byte = XFER_ST1;
        4'h2: res_byte = XFER_ST2;
        4'h3: res_byte = ids[0];
        4'h4: res_byte = ids[1];
        4'h5: res_byte = ids[2];
        4'h6: res_byte = ids[3];
        default: res_byte = 8'h00;
      endcase
      if (seek_fail && res_idx == 4'h0) begin
        res_byte = `FCM_ST0_SEEK_FAIL | {6'h00, SEEK_DRIVE};
      end
      if (seek_fail && res_idx == 4'h3) begin
        res_byte = fail_cyl;
      end
      if (seek_fail && (res_idx == 4'h1 || res_idx == 4'h2)) begin
        res_byte = 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command sequencer
  always @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      state <= S_IDLE;
      opcode <= 8'h00;
      need <= 4'h0;
      idx <= 4'h0;
      last_fmt <= 1'b0;
      eot_sector <= 8'h00;
      sc_value <= 8'h00;
      res_len <= 4'h0;
      res_idx <= 4'h0;
      push <= 1'b0;
      push_data <= 8'h00;
      id_got <= 1'b0;
      seek_fail <= 1'b0;
      fail_cyl <= 8'h00;
      CMD_BUSY <= 1'b0;
      DRIVE_BUSY <= 4'h0;
      SEEK_REQ <= 1'b0;
      SEEK_DRIVE <= 2'b00;
      SEEK_CYL <= 8'h00;
      XFER_START <= 1'b0;
      XFER_OP <= 5'h00;
      PERP_CTRL <= 8'h00;
      LOCK_FLAG <= 1'b0;
      RES_DATA <= 8'h00;
      RES_VALID <= 1'b0;
      ids[0] <= 8'h00;
      ids[1] <= 8'h00;
      ids[2] <= 8'h00;
      ids[3] <= 8'h00;
    end else begin
      SEEK_REQ <= 1'b0;
      XFER_START <= 1'b0;
      push <= 1'b0;
      RES_DATA <= f_dout;
      RES_VALID <= !f_empty && !(RES_POP && RES_VALID);
      case (state)
        S_IDLE: begin
          CMD_BUSY <= 1'b0;
          if (CMD_VALID) begin
            opcode <= CMD_DATA;
            idx <= 4'h0;
            res_idx <= 4'h0;
            seek_fail <= 1'b0;
            CMD_BUSY <= 1'b1;
            if (CMD_DATA == `FCM_OP_DUMP) begin
              res_len <= `FCM_DUMP_LEN;
              state <= S_RESULT;
            end else if (CMD_DATA[6:0] == `FCM_OP_LOCK) begin
              LOCK_FLAG <= CMD_DATA[7];
              res_len <= 4'h1;
              state <= S_RESULT;
            end else if (CMD_DATA == `FCM_OP_PERP) begin
              need <= 4'h1;
              state <= S_PARAM;
            end else if (CMD_DATA[7] == 1'b0 && CMD_DATA[5:0] == {1'b0, `FCM_OP_READ_ID}) begin
              need <= 4'h1;
              state <= S_PARAM;
            end else if (is_xfer && low5 == `FCM_OP_FORMAT) begin
              need <= 4'h5;
              state <= S_PARAM;
            end else if (is_xfer) begin
              need <= `FCM_XFER_PARAMS;
              state <= S_PARAM;
            end else if (CMD_DATA == `FCM_OP_CONFIGURE) begin
              need <= 4'h3;
              state <= S_PARAM;
            end else if (CMD_DATA == `FCM_OP_SPECIFY) begin
              need <= 4'h2;
              state <= S_PARAM;
            end else begin
              res_len <= 4'h1;
              opcode <= 8'hff;
              state <= S_RESULT;
            end
          end
        end
        S_PARAM: begin
          if (CMD_VALID) begin
            par[idx[2:0]] <= CMD_DATA;
            idx <= idx + 4'h1;
            if (idx + 4'h1 == need) begin
              if (opcode == `FCM_OP_PERP) begin
                // internal only; drive select pins stay with the output register
                PERP_CTRL <= CMD_DATA;
                state <= S_IDLE;
              end else if (opcode[4:0] == `FCM_OP_READ_ID && need == 4'h1) begin
                SEEK_DRIVE <= CMD_DATA[1:0];
                res_len <= `FCM_RID_LEN;
                id_got <= 1'b0;
                XFER_OP <= `FCM_OP_READ_ID;
                XFER_START <= 1'b1;
                state <= S_RID;
              end else if (opcode[4:0] == `FCM_OP_FORMAT && need == 4'h5) begin
                last_fmt <= 1'b1;
                sc_value <= par[2];
                XFER_OP <= `FCM_OP_FORMAT;
                XFER_START <= 1'b1;
                res_len <= `FCM_XFER_LEN;
                state <= S_XFER;
              end else if (need == `FCM_XFER_PARAMS) begin
                last_fmt <= 1'b0;
                eot_sector <= par[5];
                SEEK_DRIVE <= par[0][1:0];
                SEEK_CYL <= par[1];
                XFER_OP <= opcode[4:0];
                res_len <= `FCM_XFER_LEN;
                if (CFG_BYTE[6] && par[1] != CYL_IN[{par[0][1:0], 3'b000} +: 8]) begin
                  SEEK_REQ <= 1'b1;
                  DRIVE_BUSY[par[0][1:0]] <= 1'b1;
                  state <= S_SEEK;
                end else begin
                  XFER_START <= 1'b1;
                  state <= S_XFER;
                end
              end else begin
                state <= S_IDLE;
              end
            end
          end
        end
        S_SEEK: begin
          if (SEEK_DONE) begin
            DRIVE_BUSY[SEEK_DRIVE] <= 1'b0;
            if (SEEK_FAIL) begin
              seek_fail <= 1'b1;
              fail_cyl <= SEEK_FAIL_CYL;
              state <= S_RESULT;
            end else begin
              XFER_START <= 1'b1;
              state <= S_XFER;
            end
          end
        end
        S_XFER: begin
          if (XFER_DONE) begin
            ids[0] <= XFER_CHRN[31:24];
            ids[1] <= XFER_CHRN[23:16];
            ids[2] <= XFER_CHRN[15:8];
            ids[3] <= XFER_CHRN[7:0];
            state <= S_RESULT;
          end
        end
        S_RID: begin
          // later good identifiers are ignored, only the first is kept
          if (ID_VALID && !id_got) begin
            id_got <= 1'b1;
            ids[0] <= ID_CHRN[31:24];
            ids[1] <= ID_CHRN[23:16];
            ids[2] <= ID_CHRN[15:8];
            ids[3] <= ID_CHRN[7:0];
          end
          if (XFER_DONE) begin
            state <= S_RESULT;
          end
        end
        S_RESULT: begin
          if (res_idx == res_len) begin
            state <= S_IDLE;
          end else if (!f_full) begin
            // byte is registered with its own index so push and data line up
            push_data <= res_byte;
            push <= 1'b1;
            res_idx <= res_idx + 4'h1;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

/* fcm_consts.vh */
// constants for the floppy command interpreter block
`ifndef FCM_CONSTS_VH
`define FCM_CONSTS_VH
`define FCM_OP_DUMP 8'h0e
`define FCM_OP_READ_ID 5'h0a
`define FCM_OP_PERP 8'h12
`define FCM_OP_LOCK 7'h14
`define FCM_OP_CONFIGURE 8'h13
`define FCM_OP_SPECIFY 8'h03
`define FCM_OP_SEEK 8'h0f
`define FCM_OP_FORMAT 5'h0d
`define FCM_OP_READ 5'h06
`define FCM_OP_READ_DEL 5'h0c
`define FCM_OP_WRITE 5'h05
`define FCM_OP_WRITE_DEL 5'h09
`define FCM_OP_VERIFY 5'h16
`define FCM_ST0_INVALID 8'h80
`define FCM_ST0_SEEK_FAIL 8'h40
`define FCM_LOCK_BIT 4
`define FCM_DUMP_LEN 4'ha
`define FCM_XFER_PARAMS 4'h8
`define FCM_RID_LEN 4'h7
`define FCM_XFER_LEN 4'h7
`endif

/* fcm_result_fifo.v */
// result byte fifo for the command interpreter
`timescale 1ns/1ps
module fcm_result_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk, // system clock
  input wire rstn, // async reset, active low
  input wire flush, // empty the fifo
  input wire push, // write strobe
  input wire [WIDTH-1:0] din, // write data
  input wire pop, // read strobe
  output wire [WIDTH-1:0] dout, // head of fifo
  output wire empty, // no data
  output wire full // no room
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] rd_ptr;
  reg [AW-1:0] wr_ptr;
  reg [AW:0] count;
  wire do_push;
  wire do_pop;
  assign empty = (count == {(AW+1){1'b0}});
  assign full = (count == DEPTH[AW:0]);
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign dout = mem[rd_ptr];
  always @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr] <= din;
    end
  end
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_ptr <= {AW{1'b0}};
      wr_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else if (flush) begin
      rd_ptr <= {AW{1'b0}};
      wr_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_push && !do_pop) begin
        count <= count + {{AW{1'b0}}, 1'b1};
      end else if (do_pop && !do_push) begin
        count <= count - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

/* fcm_cmd_interp_sva.sv */
// assertions on the command interpreter ports
`timescale 1ns/1ps
module fcm_cmd_interp_sva (
  input wire CLK_SYS, // clock
  input wire RSTN, // reset, active low
  input wire CMD_VALID, // byte strobe
  input wire [7:0] CMD_DATA, // command byte
  input wire CMD_BUSY, // in progress
  input wire RES_POP, // result taken
  input wire [7:0] RES_DATA, // result byte
  input wire RES_VALID, // result ready
  input wire [3:0] DRIVE_BUSY, // drive busy
  input wire [7:0] CFG_BYTE, // configure
  input wire [31:0] CYL_IN, // cylinders
  input wire SEEK_REQ, // seek start
  input wire [1:0] SEEK_DRIVE, // seek drive
  input wire [7:0] SEEK_CYL, // seek target
  input wire SEEK_DONE, // seek end
  input wire SEEK_FAIL, // seek failed
  input wire XFER_START, // transfer start
  input wire LOCK_FLAG // lock setting
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  wire idle_cmd = CMD_VALID && !CMD_BUSY;
  wire lock_cmd = idle_cmd && CMD_DATA[6:0] == 7'h14;
  chk_invalid_reply: assert property (
    idle_cmd && (CMD_DATA == 8'h00 || CMD_DATA[4:0] == 5'h1f)
    |-> ##[1:8] RES_VALID && RES_DATA == 8'h80) else $error("invalid code reply wrong");
  chk_lock_store: assert property (
    lock_cmd |-> ##4 LOCK_FLAG == $past(CMD_DATA[7], 4)) else $error("lock flag not stored");
  chk_lock_reply: assert property (
    lock_cmd |-> ##[1:8] RES_VALID && RES_DATA == {3'h0, LOCK_FLAG, 4'h0})
    else $error("lock reply wrong");
  chk_result_stands: assert property (
    RES_VALID && !RES_POP && !CMD_VALID && !$past(RES_POP) && !$past(RES_POP, 2)
    |=> RES_VALID && $stable(RES_DATA)) else $error("result lost");
  chk_seek_gate: assert property (
    SEEK_REQ |-> CFG_BYTE[6] && SEEK_CYL != CYL_IN[SEEK_DRIVE*8 +: 8])
    else $error("seek without cause");
  chk_seek_busy: assert property (
    SEEK_REQ |-> ##[0:2] DRIVE_BUSY[SEEK_DRIVE]) else $error("drive busy missing");
  chk_busy_in_cmd: assert property (
    DRIVE_BUSY != 4'h0 |-> CMD_BUSY && !XFER_START) else $error("busy outside seek");
  chk_fail_stops: assert property (
    SEEK_DONE && SEEK_FAIL |=> !XFER_START [*8]) else $error("transfer after failed seek");
  chk_seek_then_xfer: assert property (
    SEEK_DONE && !SEEK_FAIL |-> ##[1:8] XFER_START) else $error("no transfer after seek");
  cover property (SEEK_REQ);
  cover property (SEEK_DONE && SEEK_FAIL);
  cover property (idle_cmd && CMD_DATA == 8'h0e);
endmodule
bind fcm_cmd_interp fcm_cmd_interp_sva u_sva (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
  .CMD_VALID(CMD_VALID), .CMD_DATA(CMD_DATA), .CMD_BUSY(CMD_BUSY), .RES_POP(RES_POP),
  .RES_DATA(RES_DATA), .RES_VALID(RES_VALID), .DRIVE_BUSY(DRIVE_BUSY), .CFG_BYTE(CFG_BYTE),
  .CYL_IN(CYL_IN), .SEEK_REQ(SEEK_REQ), .SEEK_DRIVE(SEEK_DRIVE), .SEEK_CYL(SEEK_CYL),
  .SEEK_DONE(SEEK_DONE), .SEEK_FAIL(SEEK_FAIL), .XFER_START(XFER_START), .LOCK_FLAG(LOCK_FLAG));

/* fcm_disk_model.sv */
// seek, transfer and identifier engines behind the interpreter
`timescale 1ns/1ps
module fcm_disk_model (
  input wire clk, // clock
  input wire rstn, // reset, active low
  input wire slow, // long answers
  input wire fail, // seeks fail
  input wire [7:0] fail_cyl, // failing cylinder
  input wire seek_req, // seek start
  input wire [1:0] seek_drive, // seek drive
  input wire [7:0] seek_cyl, // seek target
  input wire [3:0] drive_busy, // busy bits
  input wire xfer_start, // transfer start
  input wire [4:0] xfer_op, // transfer code
  output reg seek_done, // seek end
  output reg seek_fail, // valid with seek_done
  output reg [7:0] seek_fail_cyl, // valid with seek_done
  output reg xfer_done, // transfer end
  output reg id_valid, // good identifier
  output reg [31:0] id_chrn, // identifier fields
  output reg [7:0] seeks, // seeks started
  output reg [7:0] xfers, // transfers started
  output reg [7:0] s_cyl, // last target
  output reg [4:0] op, // last code
  output reg busy_seen // busy held over the last three seek counts
);
  reg [3:0] scnt;
  reg [3:0] xcnt;
  reg [1:0] s_drv;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {seek_done, seek_fail, seek_fail_cyl, xfer_done, id_valid, id_chrn} <= 0;
      {seeks, xfers, s_drv, s_cyl, op, busy_seen, scnt, xcnt} <= 0;
    end else begin
      seek_done <= 1'b0;
      xfer_done <= 1'b0;
      id_valid <= 1'b0;
      // qualified lines carry junk between answers
      seek_fail <= ~seek_fail;
      seek_fail_cyl <= ~seek_fail_cyl;
      id_chrn <= ~id_chrn;
      if (scnt != 4'h0) begin
        scnt <= scnt - 4'h1;
      end
      if (scnt != 4'h0 && scnt < 4'h4 && drive_busy[s_drv] !== 1'b1) begin
        busy_seen <= 1'b0;
      end
      if (scnt == 4'h1) begin
        seek_done <= 1'b1;
        seek_fail <= fail;
        seek_fail_cyl <= fail_cyl;
      end
      if (seek_req) begin
        scnt <= slow ? 4'hc : 4'h5;
        seeks <= seeks + 8'h01;
        s_drv <= seek_drive;
        s_cyl <= seek_cyl;
        busy_seen <= 1'b1;
      end
      if (xcnt != 4'h0) begin
        xcnt <= xcnt - 4'h1;
      end
      // two good identifiers, only the first may be kept
      if (op == 5'h0a && (xcnt == 4'h3 || xcnt == 4'h2)) begin
        id_valid <= 1'b1;
        id_chrn <= (xcnt == 4'h3) ? 32'h05000302 : 32'h06010703;
      end
      if (xcnt == 4'h1) begin
        xfer_done <= 1'b1;
      end
      if (xfer_start) begin
        xcnt <= slow ? 4'hc : 4'h5;
        xfers <= xfers + 8'h01;
        op <= xfer_op;
      end
    end
  end
endmodule

/* testbench.sv */
// self-checking bench for the floppy command interpreter
`timescale 1ns/1ps
module testbench;
  reg clk = 1'b0;
  reg rstn = 1'b0;
  reg cmd_valid = 1'b0;
  reg [7:0] cmd_data = 8'h00;
  reg res_pop = 1'b0;
  reg [7:0] cfg = 8'h1a;
  reg [15:0] spec = 16'hc72b;
  reg [7:0] pre = 8'h05;
  reg [31:0] cyl = 32'h030a1122;
  reg [55:0] xst = 56'h21041014010502;
  reg [39:0] ops = 40'h060c050916;
  reg [23:0] bad = 24'h001fff;
  reg slow = 1'b0;
  reg fail = 1'b0;
  reg [7:0] nx;
  integer n_fail = 0;
  integer checks_done = 0;
  integer cyc = 0;
  integer i;
  wire [7:0] res_data, perp, seek_cyl, fcyl;
  wire res_valid, busy, lock, seek_req, seek_done, seek_fail, xfer_start, xfer_done, id_valid;
  wire [3:0] dbusy;
  wire [1:0] seek_drive;
  wire [4:0] xfer_op;
  wire [31:0] id_chrn;
  always #10 clk = ~clk;
  fcm_cmd_interp i_fcm_cmd_interp (.CLK_SYS(clk), .RSTN(rstn), .CMD_VALID(cmd_valid),
    .CMD_DATA(cmd_data), .RES_POP(res_pop), .RES_DATA(res_data), .RES_VALID(res_valid),
    .CMD_BUSY(busy), .DRIVE_BUSY(dbusy), .SPEC_TIMES(spec[15:8]), .SPEC_LOAD(spec[7:0]),
    .CFG_BYTE(cfg), .PRECOMP_START_TRACK(pre), .CYL_IN(cyl), .SEEK_REQ(seek_req),
    .SEEK_DRIVE(seek_drive), .SEEK_CYL(seek_cyl), .SEEK_DONE(seek_done), .SEEK_FAIL(seek_fail),
    .SEEK_FAIL_CYL(fcyl), .XFER_START(xfer_start), .XFER_OP(xfer_op), .XFER_DONE(xfer_done),
    .XFER_ST0(xst[55:48]), .XFER_ST1(xst[47:40]), .XFER_ST2(xst[39:32]), .XFER_CHRN(xst[31:0]),
    .ID_VALID(id_valid), .ID_CHRN(id_chrn), .PERP_CTRL(perp), .LOCK_FLAG(lock));
  fcm_disk_model u_disk (.clk(clk), .rstn(rstn), .slow(slow), .fail(fail), .fail_cyl(8'h2c),
    .seek_req(seek_req), .seek_drive(seek_drive), .seek_cyl(seek_cyl), .drive_busy(dbusy),
    .xfer_start(xfer_start), .xfer_op(xfer_op), .seek_done(seek_done), .seek_fail(seek_fail),
    .seek_fail_cyl(fcyl), .xfer_done(xfer_done), .id_valid(id_valid), .id_chrn(id_chrn),
    .seeks(), .xfers(), .s_cyl(), .op(), .busy_seen());
  task chk8(input [63:0] nm, input [7:0] e, input [7:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("[ERR] %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task chk1(input [63:0] nm, input e, input g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask
  task done(input [63:0] nm);
    $display("test %0s finished", nm);
  endtask
  task wr(input [7:0] b);
    begin
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_data <= b;
      @(posedge clk);
      cmd_valid <= 1'b0;
    end
  endtask
  task rd(input [7:0] e);
    integer k;
    begin
      for (k = 0; k < 300 && res_valid !== 1'b1; k = k + 1) @(posedge clk) #1;
      chk8("result", e, res_data);
      @(posedge clk);
      res_pop <= 1'b1;
      @(posedge clk);
      res_pop <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
    end
  endtask
  task quiet;
    begin
      repeat (10) @(posedge clk);
      #1;
      chk1("nomore", 1'b0, res_valid);
    end
  endtask
  task drain;
    begin
      repeat (80) begin
        @(posedge clk);
        res_pop <= (res_valid === 1'b1) && !res_pop;
      end
      @(posedge clk);
      res_pop <= 1'b0;
      #1;
      chk1("idle", 1'b0, busy);
    end
  endtask
  task res7(input [55:0] v);
    integer k;
    for (k = 0; k < 7; k = k + 1) rd(v[55-8*k -: 8]);
  endtask
  task xfer(input [7:0] c, input [7:0] d, input [7:0] cy);
    begin
      wr(c); wr(d); wr(cy); wr(8'h00); wr(8'h01); wr(8'h02); wr(8'h12); wr(8'h1b); wr(8'hff);
    end
  endtask
  task dump(input [7:0] e6);
    reg [79:0] ex;
    integer k;
    begin
      ex = {cyl[7:0], cyl[15:8], cyl[23:16], cyl[31:24], spec, e6, 8'hbd, 1'b0, cfg[6:0], pre};
      wr(8'h0e);
      for (k = 0; k < 10; k = k + 1) rd(ex[79-8*k -: 8]);
      quiet;
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      close_out;
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    for (i = 0; i < 3; i = i + 1) begin
      wr(bad[23-8*i -: 8]); rd(8'h80); quiet;
    end
    done("invalid");
    wr(8'h14); rd(8'h00); chk1("lock", 1'b0, lock);
    wr(8'h94); rd(8'h10); chk1("lock", 1'b1, lock);
    done("lock");
    wr(8'h12); wr(8'hbd); quiet;
    chk8("perp", 8'hbd, perp);
    chk8("drive", 8'h00, {6'h00, seek_drive});
    done("perp");
    for (i = 0; i < 5; i = i + 1) begin
      xfer(8'h40 | ops[39-8*i -: 8], 8'h01, 8'h11); res7(xst); quiet;
      chk8("op", ops[39-8*i -: 8], {3'h0, u_disk.op});
    end
    chk8("seeks", 8'h00, u_disk.seeks);
    dump(8'h12);
    done("xfer");
    wr(8'h4d); wr(8'h01); wr(8'h02); wr(8'h09); wr(8'h54); wr(8'he5); drain;
    dump(8'h09);
    done("format");
    @(posedge clk);
    cfg <= 8'h5a;
    slow <= 1'b1;
    xfer(8'h46, 8'h01, 8'h30); res7(xst); quiet;
    chk8("seeks", 8'h01, u_disk.seeks);
    chk8("target", 8'h30, u_disk.s_cyl);
    chk1("busy", 1'b1, u_disk.busy_seen);
    done("seek");
    @(posedge clk);
    fail <= 1'b1;
    nx = u_disk.xfers;
    xfer(8'h45, 8'h02, 8'h40); rd(8'h42); rd(8'h00); rd(8'h00); rd(8'h2c); drain;
    chk8("xfers", nx, u_disk.xfers);
    done("seekfail");
    @(posedge clk);
    fail <= 1'b0;
    wr(8'h4a); wr(8'h02); res7({xst[55:32], 32'h05000302}); quiet;
    done("readid");
    close_out;
  end
endmodule
